// *** src/control_page_upper_registers.sv ***
// Purpose: upper control page registers: corner temperature sums, led delay counts, pll enable
// Assumes: register requests arrive already decoded from the serial bus, on core_clk
// Notes: sensor samples and row pulses come from same-clock logic, so no synchroniser
//
// Overview of operation
// R01 - four corner temperature results are readable as pairs of consecutive read-only registers.
// R02 - each result is the sum of four conversions and is refreshed once every fourth row read.
// R03 - a two-register fine count delays the led output about 10 ps per step, max 799.
// R04 - the fine delay only acts while the external delay-enable bit is set.
// R05 - a coarse count delays the led output about 2 ns per step, max 49.
// R06 - the coarse delay only acts while the external delay-enable bit is set.
// R07 - bit 2 of the mode register enables the pll and resets to one, giving 0x04.
// R08 - the host writes zeros to reserved mode bits and keeps delay counts within the maxima.
`timescale 1ns/1ps
module control_page_upper_registers (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // register access
  input wire ctrl_upper_pkg::reg_req_s req,
  output logic [7:0] rdata,
  output logic rvalid,
  // temperature sensor conversions
  input wire logic [3:0] conv_valid,
  input wire logic [11:0] conv_value [4],
  input wire logic row_done,
  // delay line control
  input wire logic delay_enable,
  output ctrl_upper_pkg::delay_s led_delay,
  // pll
  output logic pll_enable
);
  logic [7:0] fine_hi;
  logic [7:0] fine_lo;
  logic [7:0] coarse;
  logic [7:0] mode;
  logic [15:0] temp_result [4];
  logic [15:0] temp_acc [4];
  logic [1:0] conv_cnt [4];
  logic [1:0] row_cnt;
  logic [3:0] refresh_due;
  logic [7:0] next_rdata;

  // pair index 0..3 maps to top left, top right, bottom left, bottom right
  function automatic logic [7:0] temp_byte(input logic [15:0] v, input logic lo_half);
    temp_byte = lo_half ? v[7:0] : v[15:8];
  endfunction

  always_ff @(posedge core_clk) begin
    if (reset) begin
      fine_hi <= ctrl_upper_pkg::fine_hi_reset;
      fine_lo <= ctrl_upper_pkg::fine_lo_reset;
      coarse <= ctrl_upper_pkg::coarse_reset;
      mode <= ctrl_upper_pkg::mode_control_reset; // R07
    end else if (req.wr) begin
      case (req.addr)
        ctrl_upper_pkg::fine_delay_count_hi: fine_hi <= req.wdata;
        ctrl_upper_pkg::fine_delay_count_lo: fine_lo <= req.wdata;
        ctrl_upper_pkg::coarse_delay_count: coarse <= req.wdata;
        // reserved bits are not stored and read as zero
        ctrl_upper_pkg::mode_control: mode <= req.wdata & ctrl_upper_pkg::mode_control_mask; // R07
        default: ;
      endcase
    end
  end

  // row counter: every fourth row arms one refresh per sensor; each sensor drops its own
  // request only when it publishes, so an arm that lands between groups is not lost
  always_ff @(posedge core_clk) begin
    if (reset) begin
      row_cnt <= 2'h0;
      refresh_due <= 4'h0;
    end else begin
      if (row_done) begin
        row_cnt <= row_cnt + 2'h1;
      end
      for (int i = 0; i < ctrl_upper_pkg::sensor_count; i++) begin
        // an arm in the cycle of a publish wins, keeping the request for the next group
        if (row_done && (row_cnt == ctrl_upper_pkg::rows_per_refresh)) begin
          refresh_due[i] <= 1'b1; // R02
        end else if (conv_valid[i] &&
            (conv_cnt[i] == ctrl_upper_pkg::conversions_per_result)) begin
          refresh_due[i] <= 1'b0;
        end
      end
    end
  end

  // accumulate four conversions; the sum is only published when a refresh is due,
  // so a result always holds a complete group and never a partial sum
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < ctrl_upper_pkg::sensor_count; i++) begin
        temp_acc[i] <= 16'h0000;
        temp_result[i] <= 16'h0000;
        conv_cnt[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < ctrl_upper_pkg::sensor_count; i++) begin
        if (conv_valid[i]) begin
          if (conv_cnt[i] == ctrl_upper_pkg::conversions_per_result) begin
            temp_acc[i] <= 16'h0000;
            if (refresh_due[i]) begin
              temp_result[i] <= temp_acc[i] + {4'h0, conv_value[i]}; // R02
            end
          end else begin
            temp_acc[i] <= temp_acc[i] + {4'h0, conv_value[i]}; // R02
          end
          conv_cnt[i] <= conv_cnt[i] + 2'h1;
        end
      end
    end
  end

  always_comb begin
    next_rdata = ctrl_upper_pkg::unmapped_read;
    case (req.addr)
      ctrl_upper_pkg::temp_top_left_a: next_rdata = temp_byte(temp_result[0], 1'b0); // R01
      ctrl_upper_pkg::temp_top_left_b: next_rdata = temp_byte(temp_result[0], 1'b1); // R01
      ctrl_upper_pkg::temp_top_right_a: next_rdata = temp_byte(temp_result[1], 1'b0); // R01
      ctrl_upper_pkg::temp_top_right_b: next_rdata = temp_byte(temp_result[1], 1'b1); // R01
      ctrl_upper_pkg::temp_bottom_left_a: next_rdata = temp_byte(temp_result[2], 1'b0); // R01
      ctrl_upper_pkg::temp_bottom_left_b: next_rdata = temp_byte(temp_result[2], 1'b1); // R01
      ctrl_upper_pkg::temp_bottom_right_a: next_rdata = temp_byte(temp_result[3], 1'b0); // R01
      ctrl_upper_pkg::temp_bottom_right_b: next_rdata = temp_byte(temp_result[3], 1'b1); // R01
      ctrl_upper_pkg::fine_delay_count_hi: next_rdata = fine_hi;
      ctrl_upper_pkg::fine_delay_count_lo: next_rdata = fine_lo;
      ctrl_upper_pkg::coarse_delay_count: next_rdata = coarse;
      ctrl_upper_pkg::mode_control: next_rdata = mode;
      default: next_rdata = ctrl_upper_pkg::unmapped_read;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) begin
        rdata <= next_rdata;
      end
    end
  end

  // delay line settings; coarse counts and the 10-bit fine count from fine_hi[1:0] and fine_lo are clamped so the line never overruns
  always_ff @(posedge core_clk) begin
    if (reset) begin
      led_delay <= '0;
    end else if (delay_enable) begin
      if ({fine_hi[1:0], fine_lo} > ctrl_upper_pkg::fine_max) begin
        led_delay.fine <= ctrl_upper_pkg::fine_max; // R03
      end else begin
        led_delay.fine <= {fine_hi[1:0], fine_lo}; // R03 R04
      end
      if (coarse > {2'h0, ctrl_upper_pkg::coarse_max}) begin
        led_delay.coarse <= ctrl_upper_pkg::coarse_max; // R05
      end else begin
        led_delay.coarse <= coarse[5:0]; // R05 R06
      end
    end else begin
      led_delay <= '0; // R04 R06
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pll_enable <= 1'b1; // R07
    end else begin
      pll_enable <= mode[ctrl_upper_pkg::pll_enable_bit]; // R07
    end
  end
endmodule

// *** src/ctrl_upper_pkg.sv ***
// Purpose: constants and carrier types for the upper control page register slice
// Assumes: 8-bit register address and data from the serial control interface front end
// Notes: temperature registers are read-only, loaded from the sensor sampling logic
package ctrl_upper_pkg;
  localparam logic [7:0] temp_top_left_a = 8'h60;
  localparam logic [7:0] temp_top_left_b = 8'h61;
  localparam logic [7:0] temp_top_right_a = 8'h62;
  localparam logic [7:0] temp_top_right_b = 8'h63;
  localparam logic [7:0] temp_bottom_left_a = 8'h64;
  localparam logic [7:0] temp_bottom_left_b = 8'h65;
  localparam logic [7:0] temp_bottom_right_a = 8'h66;
  localparam logic [7:0] temp_bottom_right_b = 8'h67;
  localparam logic [7:0] fine_delay_count_hi = 8'h71;
  localparam logic [7:0] fine_delay_count_lo = 8'h72;
  localparam logic [7:0] coarse_delay_count = 8'h73;
  localparam logic [7:0] mode_control = 8'h7d;
  localparam logic [7:0] fine_hi_reset = 8'h00;
  localparam logic [7:0] fine_lo_reset = 8'h00;
  localparam logic [7:0] coarse_reset = 8'h00;
  localparam logic [7:0] mode_control_reset = 8'h04;
  localparam int pll_enable_bit = 2;
  localparam logic [7:0] mode_control_mask = 8'h04;
  localparam logic [9:0] fine_max = 10'h31f;
  localparam logic [5:0] coarse_max = 6'h31;
  localparam int fine_step_ps = 10;
  localparam int coarse_step_ps = 2000;
  localparam logic [1:0] conversions_per_result = 2'h3;
  localparam logic [1:0] rows_per_refresh = 2'h3;
  localparam int sensor_count = 4;
  localparam logic [7:0] unmapped_read = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [9:0] fine;
    logic [5:0] coarse;
  } delay_s;
endpackage

// *** tb/host_model.sv ***
// Purpose: host side of the register access port
// Assumes: requests start on the falling edge
// Notes: idle address shows the inverse of the last one
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic core_clk,
  // register access
  output ctrl_upper_pkg::reg_req_s req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(negedge core_clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: dat};
    @(negedge core_clk) req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~dat};
  endtask
  // rvalid stands in the cycle after the taking edge, so it is read as rd drops
  task automatic rd(input logic [7:0] a, output logic [7:0] dat, output logic v);
    @(negedge core_clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge core_clk) req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    v = rvalid;
    dat = rdata;
  endtask
endmodule

// *** tb/control_page_upper_registers_properties.sv ***
// Purpose: port assertions of the upper control page
// Assumes: one clock domain
// Notes: bound after the module
`timescale 1ns/1ps
module cpu_regs_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // watched ports
  input wire ctrl_upper_pkg::reg_req_s req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic delay_enable,
  input wire ctrl_upper_pkg::delay_s led_delay,
  input wire logic pll_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  rd_answer_a: assert property (req.rd |=> rvalid) else $error("no rvalid");
  rdata_hold_a: assert property (!req.rd |=> $stable(rdata)) else $error("rdata moved");
  unmapped_rd_a: assert property (req.rd && req.addr inside {8'h70, 8'h7e} |=>
    rdata == 8'h00) else $error("unmapped not zero");
  pll_follow_a: assert property (req.wr && req.addr == 8'h7d |=> ##1
    pll_enable == $past(req.wdata[2], 2)) else $error("pll mismatch");
  fine_max_a: assert property (led_delay.fine <= 10'h31f) else $error("fine over max");
  coarse_max_a: assert property (led_delay.coarse <= 6'h31) else $error("coarse over");
  delay_off_a: assert property (!delay_enable [*2] |-> led_delay == 16'h0000)
    else $error("delay while disabled");
  coarse_set_a: assert property (req.wr && req.addr == 8'h73 && req.wdata < 8'h32
    ##1 delay_enable [*2] |-> led_delay.coarse == $past(req.wdata[5:0], 2))
    else $error("coarse not applied");
  cover property (req.wr && req.addr == 8'h7d && !req.wdata[2]);
  cover property (delay_enable && led_delay.coarse == 6'h30);
  cover property (rvalid && rdata == 8'hc4);
endmodule

bind control_page_upper_registers cpu_regs_chk u_cpu_regs_chk (.core_clk(core_clk),
  .reset(reset), .req(req), .rdata(rdata), .rvalid(rvalid), .delay_enable(delay_enable),
  .led_delay(led_delay), .pll_enable(pll_enable));

// *** tb/control_page_upper_registers_tb.sv ***
// Purpose: directed register tests of the upper control page
// Assumes: host_model drives requests
// Notes: fixed conversion values per sensor, one set for each refresh scenario
`timescale 1ns/1ps
module control_page_upper_registers_tb;
  logic core_clk = 1'b0, reset = 1'b1, row_done = 1'b0, delay_enable = 1'b0;
  logic [3:0] conv_valid = 4'h0;
  logic [11:0] conv_value [4] = '{12'h0f0, 12'h0f1, 12'h0f2, 12'h0f3};
  ctrl_upper_pkg::reg_req_s req;
  ctrl_upper_pkg::delay_s led_delay;
  logic [7:0] rdata, d;
  logic rvalid, pll_enable, v;
  int errors = 0, compares = 0;
  always #12.5 core_clk = ~core_clk;
  host_model u_host_model (.core_clk(core_clk), .req(req), .rdata(rdata), .rvalid(rvalid));
  control_page_upper_registers u_control_page_upper_registers (.core_clk(core_clk),
    .reset(reset), .req(req), .rdata(rdata), .rvalid(rvalid), .conv_valid(conv_valid),
    .conv_value(conv_value), .row_done(row_done), .delay_enable(delay_enable),
    .led_delay(led_delay), .pll_enable(pll_enable));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    u_host_model.rd(a, d, v);
    check({7'h00, v, d}, {8'h01, exp});
  endtask
  task automatic end_sim();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100us;
    errors++;
    end_sim();
  end
  initial begin
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    check({15'h0, pll_enable}, 16'h0001);
    rc(8'h7d, 8'h04);
    rc(8'h71, 8'h00);
    rc(8'h72, 8'h00);
    rc(8'h73, 8'h00);
    u_host_model.wr(8'h7d, 8'h00);
    rc(8'h7d, 8'h00);
    check({15'h0, pll_enable}, 16'h0000);
    u_host_model.wr(8'h7d, 8'h04);
    u_host_model.wr(8'h71, 8'h03);
    u_host_model.wr(8'h72, 8'h1f);
    u_host_model.wr(8'h73, 8'h31);
    rc(8'h72, 8'h1f);
    rc(8'h71, 8'h03);
    rc(8'h73, 8'h31);
    check(led_delay, 16'h0000);
    check({15'h0, pll_enable}, 16'h0001);
    delay_enable = 1'b1;
    u_host_model.wr(8'h73, 8'h30);
    repeat (2) @(negedge core_clk);
    check(led_delay, {10'h31f, 6'h30});
    // rows arrive while sensor 0 is mid-group, so the refresh is armed before a wrap
    for (int i = 0; i < 16; i++) begin
      // three rows and three complete groups so far: nothing may be published yet
      if (i == 12) begin
        rc(8'h61, 8'h00);
      end
      conv_valid = 4'hf;
      row_done = (i % 4 == 1);
      @(negedge core_clk);
      conv_valid = 4'h0;
      row_done = 1'b0;
      @(negedge core_clk);
    end
    // each sum is 4 x (0x0f0 + s) = 0x03c0 + 4s
    for (int s = 0; s < 4; s++) begin
      rc(8'h60 + 8'(2 * s), 8'h03);
      rc(8'h61 + 8'(2 * s), 8'hc0 + 8'(4 * s));
    end
    u_host_model.wr(8'h60, 8'hff);
    rc(8'h60, 8'h03);
    rc(8'h70, 8'h00);
    rc(8'h7e, 8'h00);
    // rows now land in idle cycles and the fourth one just after a group ends,
    // so the armed refresh has to wait for the next complete group
    conv_value = '{12'h010, 12'h011, 12'h012, 12'h013};
    for (int i = 0; i < 12; i++) begin
      conv_valid = 4'hf;
      @(negedge core_clk);
      conv_valid = 4'h0;
      row_done = (i < 8) && (i % 2 == 1);
      @(negedge core_clk);
      row_done = 1'b0;
    end
    // each sum is 4 x (0x010 + s) = 0x0040 + 4s
    for (int s = 0; s < 4; s++) begin
      rc(8'h60 + 8'(2 * s), 8'h00);
      rc(8'h61 + 8'(2 * s), 8'h40 + 8'(4 * s));
    end
    end_sim();
  end
endmodule
